// ==== logic/egc_governor_config.sv ====
// configuration and minor alarm logic of a marine engine speed governor
// assumes an ahb-lite master with single word transfers and synchronous plant inputs
//
// Notes on behaviour
// RULE_01 - configuration mode forces all outputs off
// RULE_02 - each pickup has its own clamped tooth count
// RULE_03 - rated speed setting held within range
// RULE_04 - engine stop resets reference to idle
// RULE_05 - power-up may start reference at idle
// RULE_06 - link loss forces idle or freezes reference
// RULE_07 - linear map scales gain and reset
// RULE_08 - speed-qualified second dynamics set
// RULE_09 - clutch-qualified second dynamics set
// RULE_10 - speed loss goes minimum or maximum fuel
// RULE_11 - polarity bit selects direct or reverse
// RULE_12 - remote failure holds or ramps low
// RULE_13 - contact f declutch or overspeed test
// RULE_14 - manual clutch: no permissive, share on engage
// RULE_15 - contact e alarm reset or dynamics
// RULE_16 - synchronizer gain selected by bit
// RULE_17 - major alarm may force minimum fuel
// RULE_18 - minor relay is OR of enabled sources
// RULE_19 - every minor source has enable bit
// RULE_20 - live-condition sources do not latch
// RULE_21 - both-port error needs both ports
// RULE_22 - clutch fail after sync window expires
// RULE_23 - partner unit takes opposite engine side; this block has no engine side setting or output
// RULE_24 - latched sources held until alarm reset
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "egc_defines.svh"

module egc_governor_config #(
    parameter int unsigned RAMP_CYCLES = `EGC_RAMP_CYCLES,
    parameter int unsigned NSRC        = 16
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // plant conditions
    input  wire logic                  speedLost,
    input  wire logic                  engineStopped,
    input  wire logic                  aboveDynSpeed,
    input  wire logic                  clutchEngaged,
    input  wire logic                  clutchRequest,
    input  wire logic                  linkOk,
    input  wire logic                  remoteFailed,
    input  wire logic                  majorAlarm,
    input  wire logic                  contactE,
    input  wire logic                  contactF,
    input  wire logic [NSRC-1:0]       alarmCond,
    // outputs
    output logic                       minorRelay,
    output logic                       clutchPermissive,
    output logic                       loadShareEn,
    output logic                       softUnloadEn,
    output logic                       minFuel,
    output logic                       maxFuel,
    output logic                       reverseAct,
    output logic                       secondDynamicsSet,
    output logic                       linearDynMap,
    output logic                       syncHighGain,
    output logic                       emergencyDeclutch,
    output logic                       overspeedTestEn,
    output logic                       outputsOff,
    output egc_pkg::egc_ref_sel_t      refSelect,
    output logic                       refRamp
);
    import egc_pkg::*;

    // source indices: 0,1 pickups, 2 manifold, 3 remote, 4 rack, 5 speed switch,
    // 6 torque lim, 7 manifold lim, 8 high act, 9 port2, 10 port3, 11 both ports,
    // 12 controller_output_low_fault, 13 overspeed, 14 load switch, 15 clutch fail
    localparam logic [NSRC-1:0] LIVE_MASK = 16'h40E0;

    // registers
    logic [31:0]         cfg;           // option bits
    logic [8:0]          teeth1;        // pickup 1 tooth count
    logic [8:0]          teeth2;        // pickup 2 tooth count
    logic [11:0]         ratedRpm;      // rated speed
    logic [NSRC-1:0]     minorEn;       // per-source enables
    logic [NSRC-1:0]     latched;       // held alarm bits
    logic [31:0]         clutchTmo;     // sync window in cycles
    logic [31:0]         clutchCnt;     // sync window counter
    logic [31:0]         rampCnt;       // one-second wait
    logic                menuReset;     // software alarm reset pulse
    logic                powerUp;       // first cycles after reset
    egc_seq_t            seq;           // reference sequencer
    egc_clu_t            cluState;      // clutch watchdog
    // bus address phase capture
    logic                dpWrite;
    logic                dpRead;
    logic [11:0]         dpAddr;

    // ahb address phase decode
    wire logic           busTake  = hsel & hready & htrans[1];
    wire logic           ioLock   = cfg[`EGC_CFG_IO_LOCK];
    wire logic [8:0]     wTeeth1  = hwdata[8:0];
    wire logic [8:0]     wTeeth2  = hwdata[24:16];
    wire logic [11:0]    wRated   = hwdata[11:0];

    // bus phase register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dpWrite <= 1'b0;
            dpRead  <= 1'b0;
            dpAddr  <= 12'h000;
        end else begin
            dpWrite <= busTake & hwrite;
            dpRead  <= busTake & ~hwrite;
            dpAddr  <= haddr;
        end
    end

    // clamp functions for settings
    function automatic logic [8:0] clampTeeth(input logic [8:0] v);
        if (v < `EGC_TEETH_MIN) clampTeeth = `EGC_TEETH_MIN;
        else if (v > `EGC_TEETH_MAX) clampTeeth = `EGC_TEETH_MAX;
        else clampTeeth = v;
    endfunction
    function automatic logic [11:0] clampRated(input logic [11:0] v);
        if (v < `EGC_RATED_MIN) clampRated = `EGC_RATED_MIN;
        else if (v > `EGC_RATED_MAX) clampRated = `EGC_RATED_MAX;
        else clampRated = v;
    endfunction

    // register writes in the data phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg       <= `EGC_CFG_RESET;
            teeth1    <= 9'h03C;
            teeth2    <= 9'h03C;
            ratedRpm  <= `EGC_RATED_RESET;
            minorEn   <= '0;
            clutchTmo <= `EGC_CLUTCH_RESET;
            menuReset <= 1'b0;
        end else begin
            menuReset <= dpWrite && dpAddr == `EGC_REG_CMD && hwdata[0];
            if (dpWrite) begin
                unique case (dpAddr)
                    `EGC_REG_CFG:        cfg       <= hwdata;
                    `EGC_REG_TEETH: begin
                        teeth1 <= clampTeeth(wTeeth1);  // RULE_02
                        teeth2 <= clampTeeth(wTeeth2);  // RULE_02
                    end
                    `EGC_REG_RATED:      ratedRpm  <= clampRated(wRated); // RULE_03
                    `EGC_REG_MINOR_EN:   minorEn   <= hwdata[NSRC-1:0];   // RULE_19
                    `EGC_REG_CLUTCH_TMO: clutchTmo <= hwdata;
                    default: ;
                endcase
            end
        end
    end

    // read mux and response
    logic [31:0] rdMux;
    always_comb begin
        unique case (dpAddr)
            `EGC_REG_CFG:        rdMux = cfg;
            `EGC_REG_TEETH:      rdMux = {7'h00, teeth2, 7'h00, teeth1};
            `EGC_REG_RATED:      rdMux = {20'h0_0000, ratedRpm};
            `EGC_REG_MINOR_EN:   rdMux = {16'h0000, minorEn};
            `EGC_REG_STATUS:     rdMux = {16'h0000, 12'h000, secondDynamicsSet,
                                          minFuel, maxFuel, minorRelay};
            `EGC_REG_LATCHED:    rdMux = {16'h0000, latched};
            `EGC_REG_REFS:       rdMux = {28'h000_0000, refRamp, refSelect};
            `EGC_REG_CLUTCH_TMO: rdMux = clutchTmo;
            default:             rdMux = 32'h0000_0000;
        endcase
    end
    always_comb hrdata = rdMux;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // alarm reset source: contact e in reset mode or menu
    wire logic alarmReset = menuReset | (contactE & cfg[`EGC_CFG_CT_E_SEL]); // RULE_15 RULE_24

    // clutch watchdog: request starts window, engage ends it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cluState  <= EGC_CLU_OFF;
            clutchCnt <= 32'h0000_0000;
        end else begin
            unique case (cluState)
                EGC_CLU_OFF: begin
                    clutchCnt <= 32'h0000_0000;
                    if (clutchRequest & ~clutchEngaged) cluState <= EGC_CLU_WAIT;
                end
                EGC_CLU_WAIT: begin
                    clutchCnt <= clutchCnt + 32'h0000_0001;
                    if (clutchEngaged | ~clutchRequest) cluState <= EGC_CLU_OFF;
                    else if (clutchCnt >= clutchTmo) cluState <= EGC_CLU_FAIL; // RULE_22
                end
                EGC_CLU_FAIL: begin
                    if (~clutchRequest) cluState <= EGC_CLU_OFF;
                end
            endcase
        end
    end

    // effective source conditions
    logic [NSRC-1:0] srcNow;
    always_comb begin
        srcNow     = alarmCond;
        srcNow[11] = alarmCond[9] & alarmCond[10]; // RULE_21
        srcNow[15] = (cluState == EGC_CLU_FAIL);   // RULE_22
    end

    // latching sources; set wins over reset
    always_ff @(posedge core_clk) begin
        if (rst) latched <= '0;
        else latched <= (alarmReset ? '0 : latched) | (srcNow & ~LIVE_MASK); // RULE_24
    end
    wire logic [NSRC-1:0] contrib = ((srcNow & LIVE_MASK) | latched) & minorEn; // RULE_20
    wire logic            minorAny = |contrib; // RULE_18

    // reference sequencer with one-second idle wait
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq     <= EGC_SEQ_IDLE_WAIT;
            powerUp <= 1'b1;
            rampCnt <= 32'h0000_0000;
        end else begin
            unique case (seq)
                EGC_SEQ_RUN: begin
                    rampCnt <= 32'h0000_0000;
                    if (engineStopped & cfg[`EGC_CFG_IDLE_SD]) seq <= EGC_SEQ_IDLE_WAIT; // RULE_04
                end
                EGC_SEQ_IDLE_WAIT: begin
                    rampCnt <= rampCnt + 32'h0000_0001;
                    if (rampCnt >= RAMP_CYCLES - 1) begin
                        powerUp <= 1'b0;
                        if (~engineStopped) seq <= EGC_SEQ_RUN;
                    end
                end
            endcase
        end
    end

    // reference selection priority
    egc_ref_sel_t next_ref;
    logic         next_ramp;
    wire logic    remoteSel = cfg[`EGC_CFG_REMOTE_SEL];
    wire logic    atIdle    = (seq == EGC_SEQ_IDLE_WAIT) &
                              (~powerUp | cfg[`EGC_CFG_PWRUP_IDLE]); // RULE_05
    always_comb begin
        next_ramp = 1'b0;
        if (~linkOk)
            next_ref = cfg[`EGC_CFG_IDLE_COMM] ? EGC_REF_IDLE : EGC_REF_HOLD; // RULE_06
        else if (atIdle)
            next_ref = EGC_REF_IDLE; // RULE_04
        else if (seq == EGC_SEQ_RUN && engineStopped)
            next_ref = EGC_REF_HOLD; // RULE_04
        else if (remoteSel & remoteFailed) begin
            next_ref  = cfg[`EGC_CFG_REM_HOLD] ? EGC_REF_HOLD : EGC_REF_LOWER; // RULE_12
            next_ramp = ~cfg[`EGC_CFG_REM_HOLD];
        end else if (remoteSel) begin
            next_ref  = EGC_REF_REMOTE;
            next_ramp = 1'b1; // RULE_05
        end else
            next_ref = EGC_REF_RATED;
    end

    // fuel, dynamics and contact decode
    wire logic reverse   = cfg[`EGC_CFG_REVERSE]; // RULE_11
    wire logic lossMax   = speedLost & cfg[`EGC_CFG_MAX_FUEL] & reverse; // RULE_10
    wire logic next_min  = (speedLost & ~lossMax) |
                           (majorAlarm & cfg[`EGC_CFG_MAJ_SD]); // RULE_10 RULE_17
    wire logic dynCt     = contactE & ~cfg[`EGC_CFG_CT_E_SEL]; // RULE_15
    wire logic next_dyn  = dynCt &
                           (~cfg[`EGC_CFG_SET2_SPD] | aboveDynSpeed) & // RULE_08
                           (~cfg[`EGC_CFG_SET2_CLU] | clutchEngaged);  // RULE_09
    wire logic manClutch = cfg[`EGC_CFG_MAN_CLUTCH];
    wire logic next_perm = clutchRequest & ~manClutch & ~clutchEngaged; // RULE_14

    // output registers, all but outputsOff forced off under the io lock, outputsOff set
    always_ff @(posedge core_clk) begin
        if (rst || ioLock) begin // RULE_01
            minorRelay        <= 1'b0;
            clutchPermissive  <= 1'b0;
            loadShareEn       <= 1'b0;
            softUnloadEn      <= 1'b0;
            minFuel           <= 1'b0;
            maxFuel           <= 1'b0;
            reverseAct        <= 1'b0;
            secondDynamicsSet <= 1'b0;
            linearDynMap      <= 1'b0;
            syncHighGain      <= 1'b0;
            emergencyDeclutch <= 1'b0;
            overspeedTestEn   <= 1'b0;
            refSelect         <= EGC_REF_IDLE;
            refRamp           <= 1'b0;
            outputsOff        <= 1'b1;
        end else begin
            minorRelay        <= minorAny; // RULE_18
            clutchPermissive  <= next_perm; // RULE_14
            loadShareEn       <= clutchEngaged; // RULE_14
            softUnloadEn      <= ~manClutch; // RULE_14
            minFuel           <= next_min;
            maxFuel           <= lossMax & ~next_min; // RULE_10
            reverseAct        <= reverse; // RULE_11
            secondDynamicsSet <= next_dyn;
            linearDynMap      <= cfg[`EGC_CFG_LINEAR_DYN]; // RULE_07
            syncHighGain      <= cfg[`EGC_CFG_SYNC_GAIN]; // RULE_16
            emergencyDeclutch <= contactF & ~cfg[`EGC_CFG_CT_F_SEL]; // RULE_13
            overspeedTestEn   <= contactF & cfg[`EGC_CFG_CT_F_SEL]; // RULE_13
            refSelect         <= next_ref;
            refRamp           <= next_ramp;
            outputsOff        <= 1'b0;
        end
    end
endmodule

// ==== logic/egc_defines.svh ====
// register offsets, field positions, reset values and timing counts of the governor config block
// assumes inclusion by the top module and the bench top only
`ifndef EGC_DEFINES_SVH
`define EGC_DEFINES_SVH
// register byte offsets
`define EGC_REG_CFG        12'h000
`define EGC_REG_TEETH      12'h004
`define EGC_REG_RATED      12'h008
`define EGC_REG_MINOR_EN   12'h00C
`define EGC_REG_CMD        12'h010
`define EGC_REG_STATUS     12'h014
`define EGC_REG_LATCHED    12'h018
`define EGC_REG_SPEEDS     12'h01C
`define EGC_REG_REFS       12'h020
`define EGC_REG_CLUTCH_TMO 12'h024
// configuration bit positions
`define EGC_CFG_IO_LOCK     0
`define EGC_CFG_IDLE_SD     1
`define EGC_CFG_PWRUP_IDLE  2
`define EGC_CFG_IDLE_COMM   3
`define EGC_CFG_LINEAR_DYN  4
`define EGC_CFG_SET2_SPD    5
`define EGC_CFG_SET2_CLU    6
`define EGC_CFG_REM_HOLD    7
`define EGC_CFG_MAX_FUEL    8
`define EGC_CFG_REVERSE     9
`define EGC_CFG_CT_F_SEL    10
`define EGC_CFG_MAN_CLUTCH  11
`define EGC_CFG_CT_E_SEL    12
`define EGC_CFG_SYNC_GAIN   13
`define EGC_CFG_MAJ_SD      14
`define EGC_CFG_REMOTE_SEL  15
// reset values
`define EGC_CFG_RESET      32'h0000_0000
`define EGC_TEETH_RESET    32'h003C_003C
`define EGC_RATED_RESET    12'h3E8
`define EGC_TEETH_MIN      9'h010
`define EGC_TEETH_MAX      9'h12C
`define EGC_RATED_MIN      12'h064
`define EGC_RATED_MAX      12'h898
// ramp delay of one second
`define EGC_RAMP_DELAY_MS  1000
`define EGC_CLK_MHZ        125
`define EGC_RAMP_CYCLES    (`EGC_RAMP_DELAY_MS * 1000 * `EGC_CLK_MHZ)
`define EGC_CLUTCH_RESET   32'h0098_9680
`endif

// ==== logic/egc_pkg.sv ====
// types shared by the governor config block
// takes no numbers from the defines header
package egc_pkg;
    // speed reference selection
    typedef enum logic [2:0] {
        EGC_REF_IDLE,
        EGC_REF_RATED,
        EGC_REF_REMOTE,
        EGC_REF_HOLD,
        EGC_REF_LOWER
    } egc_ref_sel_t;
    // reference sequencer states
    typedef enum logic [1:0] {
        EGC_SEQ_RUN,
        EGC_SEQ_IDLE_WAIT
    } egc_seq_t;
    // clutch watchdog states
    typedef enum logic [1:0] {
        EGC_CLU_OFF,
        EGC_CLU_WAIT,
        EGC_CLU_FAIL
    } egc_clu_t;
endpackage

// ==== tb/egc_governor_config_sva.sv ====
// port checker of the governor config block
// assumes binding onto every egc_governor_config instance
`timescale 1ns/100ps
module egc_governor_config_sva #(
    parameter int unsigned NSRC = 16
) (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // bus answer
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    // plant inputs
    input wire logic                  speedLost,
    input wire logic                  clutchRequest,
    input wire logic                  contactE,
    input wire logic                  contactF,
    input wire logic [NSRC-1:0]       alarmCond,
    // outputs
    input wire logic                  minorRelay,
    input wire logic                  clutchPermissive,
    input wire logic                  loadShareEn,
    input wire logic                  minFuel,
    input wire logic                  maxFuel,
    input wire logic                  reverseAct,
    input wire logic                  secondDynamicsSet,
    input wire logic                  emergencyDeclutch,
    input wire logic                  overspeedTestEn,
    input wire logic                  outputsOff,
    input wire egc_pkg::egc_ref_sel_t refSelect
);
    import egc_pkg::*;
    // one domain, reset disables everything
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // lock keeps relays, permissive and fuel override dark
    chk_lock_quiet: assert property (outputsOff |-> !(minorRelay | clutchPermissive | loadShareEn
        | maxFuel | emergencyDeclutch | overspeedTestEn)) else $error("output live under lock");
    // minimum fuel wins over maximum fuel
    chk_fuel_excl: assert property (!(minFuel && maxFuel)) else $error("both fuel ends");
    // maximum fuel needs a lost speed and reverse acting
    chk_max_cause: assert property (maxFuel |-> $past(speedLost) && reverseAct)
        else $error("max fuel without cause");
    // zero wait, always okay
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    // second set never without the contact
    chk_dyn_contact: assert property (secondDynamicsSet |-> $past(contactE))
        else $error("second set without contact");
    // contact f goes to exactly one function
    chk_f_route: assert property ((emergencyDeclutch || overspeedTestEn) |->
        $past(contactF) && !(emergencyDeclutch && overspeedTestEn)) else $error("contact f route");
    // relay rises only after some source was live
    chk_minor_cause: assert property ($rose(minorRelay) |-> $past(|alarmCond)
        || $past(|alarmCond, 2) || $past(clutchRequest, 2)) else $error("relay without source");
    // first edge after reset shows the reset state
    chk_reset_state: assert property ($fell(rst) |-> outputsOff && refSelect == EGC_REF_IDLE
        && !minorRelay) else $error("reset state wrong");
endmodule

bind egc_governor_config egc_governor_config_sva #(.NSRC(NSRC)) u_chk (
    .core_clk(core_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
    .speedLost(speedLost), .clutchRequest(clutchRequest), .contactE(contactE),
    .contactF(contactF), .alarmCond(alarmCond), .minorRelay(minorRelay),
    .clutchPermissive(clutchPermissive), .loadShareEn(loadShareEn), .minFuel(minFuel),
    .maxFuel(maxFuel), .reverseAct(reverseAct), .secondDynamicsSet(secondDynamicsSet),
    .emergencyDeclutch(emergencyDeclutch), .overspeedTestEn(overspeedTestEn),
    .outputsOff(outputsOff), .refSelect(refSelect)
);

// ==== tb/egc_governor_config_tb_top.sv ====
// self-checking bench of the governor config block
// assumes the defines header and package compiled before it
`timescale 1ns/100ps
`include "egc_defines.svh"
module egc_governor_config_tb_top;
    import egc_pkg::*;
    localparam int unsigned RAMP = 20;    // short idle wait
    localparam int SL = 9, ES = 8, AD = 7, CE = 6, CR = 5, LK = 4, RF = 3, MJ = 2, E = 1, F = 0;
    logic          core_clk  = 1'b0;      // 125 MHz
    logic          rst       = 1'b1;      // sync reset
    logic          hsel      = 1'b0;      // bus request
    logic          hwrite    = 1'b0;
    logic [11:0]   haddr     = 12'h000;
    logic [1:0]    htrans    = 2'h0;
    logic [31:0]   hwdata    = 32'h0000_0000;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic [9:0]    plant     = 10'h010;   // packed levels, link up
    logic [15:0]   alarmCond = 16'h0000;  // alarm sources
    logic [15:0]   outv;                  // packed outputs
    logic          minorRelay;
    egc_ref_sel_t  refSelect;
    int            nErrors   = 0;
    int            nChecks   = 0;
    logic [31:0]   rs        = 32'd12553; // xorshift state
    logic [31:0]   q;
    logic [31:0]   r;
    // clock
    always #4 core_clk = ~core_clk;
    egc_governor_config #(.RAMP_CYCLES(RAMP), .NSRC(16)) i_dut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .speedLost(plant[SL]),
        .engineStopped(plant[ES]), .aboveDynSpeed(plant[AD]), .clutchEngaged(plant[CE]),
        .clutchRequest(plant[CR]), .linkOk(plant[LK]), .remoteFailed(plant[RF]),
        .majorAlarm(plant[MJ]), .contactE(plant[E]), .contactF(plant[F]), .alarmCond(alarmCond),
        .minorRelay(minorRelay), .clutchPermissive(outv[3]), .loadShareEn(outv[2]),
        .softUnloadEn(outv[1]), .minFuel(outv[10]), .maxFuel(outv[11]), .reverseAct(outv[9]),
        .secondDynamicsSet(outv[8]), .linearDynMap(outv[7]), .syncHighGain(outv[6]),
        .emergencyDeclutch(outv[5]), .overspeedTestEn(outv[4]), .outputsOff(outv[0]),
        .refSelect(refSelect), .refRamp()
    );
    assign outv[15:12] = {1'b0, refSelect};
    // xorshift generator
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // clamp a setting into its range
    function automatic logic [11:0] clampv(input logic [11:0] v, input logic [11:0] lo,
                                           input logic [11:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // word compare
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // single transfer, held until hready seen high
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // masked register read compare
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        check_word(q & m, exp);
    endtask
    // change alarm sources, then let outputs settle
    task automatic cond_set(input logic [15:0] v);
        @(posedge core_clk);
        alarmCond <= v;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    // configure, apply plant levels, compare masked outputs
    task automatic scen(input logic [31:0] c, input logic [9:0] p, input logic [15:0] m,
                        input logic [15:0] exp);
        ahb(1'b1, `EGC_REG_CFG, c);
        @(posedge core_clk);
        plant <= p ^ 10'h010;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check_word({16'h0000, outv & m}, {16'h0000, exp});
    endtask
    // verdict and end of run
    task automatic closeOut();
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        closeOut();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check_word(32'(refSelect), 32'(EGC_REF_RATED));
        rd_chk(`EGC_REG_CFG, 32'hFFFF_FFFF, `EGC_CFG_RESET);
        rd_chk(`EGC_REG_TEETH, 32'h01FF_01FF, `EGC_TEETH_RESET);
        rd_chk(`EGC_REG_RATED, 32'h0000_0FFF, 32'(`EGC_RATED_RESET));
        ahb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
        rd_chk(12'hFFC, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int k = 0; k < 10; k++) begin
            r = (k == 0) ? 32'h0005_0190 : ((k == 1) ? 32'h012C_0010 : rnd());
            ahb(1'b1, `EGC_REG_TEETH, r);
            rd_chk(`EGC_REG_TEETH, 32'h01FF_01FF, {7'h00, 9'(clampv(12'(r[24:16]),
                   12'h010, 12'h12C)), 7'h00, 9'(clampv(12'(r[8:0]), 12'h010, 12'h12C))});
            ahb(1'b1, `EGC_REG_RATED, r);
            rd_chk(`EGC_REG_RATED, 32'h0000_0FFF, 32'(clampv(r[11:0], 12'h064, 12'h898)));
        end
        scen(32'h0000_22F1, 10'h201, 16'h0FFF, 16'h0001);
        scen(32'h0000_0000, 10'h000, 16'h0FF1, 16'h0000);
        scen(32'h0000_0100, 10'h200, 16'h0E00, 16'h0400);
        scen(32'h0000_0200, 10'h200, 16'h0E00, 16'h0600);
        scen(32'h0000_0300, 10'h200, 16'h0E00, 16'h0A00);
        scen(32'h0000_4000, 10'h004, 16'h0C00, 16'h0400);
        scen(32'h0000_0000, 10'h004, 16'h0C00, 16'h0000);
        scen(32'h0000_0010, 10'h000, 16'h0080, 16'h0080);
        scen(32'h0000_2000, 10'h000, 16'h0040, 16'h0040);
        scen(32'h0000_0000, 10'h001, 16'h0030, 16'h0020);
        scen(32'h0000_0400, 10'h001, 16'h0030, 16'h0010);
        scen(32'h0000_0020, 10'h002, 16'h0100, 16'h0000);
        scen(32'h0000_0020, 10'h082, 16'h0100, 16'h0100);
        scen(32'h0000_0040, 10'h042, 16'h0100, 16'h0100);
        scen(32'h0000_0040, 10'h002, 16'h0100, 16'h0000);
        scen(32'h0000_1020, 10'h082, 16'h0100, 16'h0000);
        scen(32'h0000_0800, 10'h060, 16'h000E, 16'h0004);
        scen(32'h0000_8080, 10'h008, 16'h7000, 16'h3000);
        scen(32'h0000_8000, 10'h008, 16'h7000, 16'h4000);
        scen(32'h0000_0008, 10'h010, 16'h7000, 16'h0000);
        scen(32'h0000_0000, 10'h010, 16'h7000, 16'h3000);
        scen(32'h0000_0000, 10'h100, 16'h7000, 16'h3000);
        scen(32'h0000_0002, 10'h100, 16'h7000, 16'h0000);
        ahb(1'b1, `EGC_REG_CMD, 32'h0000_0001);
        for (int i = 0; i < 15; i++) begin
            if (i == 11) continue;
            ahb(1'b1, `EGC_REG_MINOR_EN, 32'(1) << i);
            cond_set(16'(1) << i);
            check_word(32'(minorRelay), 32'h0000_0001);
            cond_set(16'h0000);
            check_word(32'(minorRelay), 32'(!(i inside {5, 6, 7, 14})));
            ahb(1'b1, `EGC_REG_CMD, 32'h0000_0001);
            cond_set(16'h0000);
            check_word(32'(minorRelay), 32'h0000_0000);
        end
        ahb(1'b1, `EGC_REG_MINOR_EN, 32'h0000_0800);
        cond_set(16'h0200);
        check_word(32'(minorRelay), 32'h0000_0000);
        cond_set(16'h0600);
        check_word(32'(minorRelay), 32'h0000_0001);
        ahb(1'b1, `EGC_REG_MINOR_EN, 32'h0000_0000);
        cond_set(16'hFFFF);
        check_word(32'(minorRelay), 32'h0000_0000);
        cond_set(16'h0000);
        ahb(1'b1, `EGC_REG_CMD, 32'h0000_0001);
        ahb(1'b1, `EGC_REG_CLUTCH_TMO, 32'h0000_0008);
        ahb(1'b1, `EGC_REG_MINOR_EN, 32'h0000_8000);
        scen(32'h0000_0000, 10'h020, 16'h0000, 16'h0000);
        check_word(32'(minorRelay), 32'h0000_0000);
        cond_set(16'h0000);
        repeat (8) @(posedge core_clk);
        check_word(32'(minorRelay), 32'h0000_0001);
        scen(32'h0000_0000, 10'h000, 16'h0000, 16'h0000);
        ahb(1'b1, `EGC_REG_CMD, 32'h0000_0001);
        for (int k = 0; k < 20; k++) begin
            r = rnd();
            ahb(1'b1, `EGC_REG_MINOR_EN, {16'h0000, r[15:0]});
            cond_set(r[31:16] & 16'h40E0);
            check_word(32'(minorRelay), 32'(|(r[15:0] & r[31:16] & 16'h40E0)));
        end
        closeOut();
    end
endmodule
